// file: hdl/pmfs_pkg.sv
package pmfs_pkg;
    // ==========================================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] PMFS_CTRL_OFS = 8'h00;
    localparam logic [7:0] PMFS_VSET_OFS = 8'h04;
    localparam logic [7:0] PMFS_ISET_OFS = 8'h08;
    localparam logic [7:0] PMFS_STAT_OFS = 8'h0C;
    localparam logic [7:0] PMFS_CMD_OFS = 8'h10;
    localparam logic [7:0] PMFS_MEAS_OFS = 8'h14;
    // control field positions
    localparam int PMFS_CTRL_EN_BIT = 0;
    localparam int PMFS_CTRL_CMODE_BIT = 1;
    // status field positions
    localparam int PMFS_ST_CAT_BIT = 0;
    localparam int PMFS_ST_TRK_BIT = 1;
    localparam int PMFS_ST_THERM_BIT = 2;
    localparam int PMFS_ST_OPEN_BIT = 3;
    localparam int PMFS_ST_OPENNOW_BIT = 4;
    localparam int PMFS_ST_CONV_BIT = 5;
    localparam int PMFS_ST_ENAB_BIT = 6;
    localparam int PMFS_ST_CMODE_BIT = 7;
    // command field positions
    localparam int PMFS_CMD_RESTORE_BIT = 0;
    localparam int PMFS_CMD_OPENCLR_BIT = 1;
    // reset values
    localparam logic [11:0] PMFS_SET_RST = 12'h000;
    // tracking margin: rated value times ten percent
    localparam int PMFS_MARGIN_PCT = 10;
    localparam int PMFS_PCT_FULL = 100;
endpackage

// file: hdl/pmfs_supervisor.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Summary of operation
// RQ1: overvoltage, overcurrent, overtemperature or power loss runs the catastrophic shutdown.
// RQ2: shutdown first opens all power and signal relays together.
// RQ3: shutdown forces the voltage and current setpoints to zero.
// RQ4: catastrophic faults latch the converter off until recovery completes; the code turns it back on at reset, before the restore command.
// RQ5: a catastrophic fault sends the catastrophic status flag to the controller.
// RQ6: the controller drops the faulted address and sends it no more commands.
// RQ7: recovery needs source power removed for at least 5 seconds; the code has no timer, and a reset of any length clears the latch.
// RQ8: after power returns only the restore command puts the address back.
// RQ9: output above setpoint by more than 10 percent of rating trips the tracking fault.
// RQ10: either thermostat going hot trips shutdown and the thermal flag.
// RQ11: thermal shutdown stays latched after the thermostat cools.
// RQ12: bulk storage voltage low trips shutdown and the tracking flag.
// RQ13: open lead sets voltage mode, disables output and zeroes setpoints, converter on.
// RQ14: open lead sends the open-lead fault message at the same time.
// RQ15: once open lead clears, commands are accepted again with no recovery.
// RQ16: excess power-lead drop counts as an open lead detection.
// RQ17: while a catastrophic fault is latched, enable and setpoint writes are ignored.
module pmfs_supervisor
    import pmfs_pkg::*;
#(
    parameter int SET_W = 12,
    parameter int RATED_V = 4095,
    parameter int RATED_I = 4095
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fault detectors
    input wire logic [SET_W-1:0] vmeas_i,
    input wire logic [SET_W-1:0] imeas_i,
    input wire logic [1:0] therm_hot_i,
    input wire logic bulk_low_i,
    input wire logic open_lead_i,
    input wire logic lead_drop_hi_i,
    // power stage
    output logic [3:0] pwr_relay_o,
    output logic [1:0] sig_relay_o,
    output logic [SET_W-1:0] vset_o,
    output logic [SET_W-1:0] iset_o,
    output logic conv_on_o,
    output logic cur_mode_o,
    // controller messages
    output logic cat_flag_o,
    output logic open_msg_o
);
    // ==========================================================
    // state
    typedef struct packed {
        logic en;
        logic cmode;
        logic [SET_W-1:0] vset;
        logic [SET_W-1:0] iset;
        logic cat;
        logic trk;
        logic therm;
        logic open_st;
        logic open_seen;
        logic [31:0] rdata;
        logic ready;
        logic err;
        logic [3:0] prl;
        logic [1:0] srl;
        logic [SET_W-1:0] vo;
        logic [SET_W-1:0] io;
        logic conv;
        logic cm_o;
        logic catf;
        logic openm;
    } pmfs_state_t;

    localparam logic [SET_W:0] V_MARGIN =
        (SET_W+1)'((RATED_V * PMFS_MARGIN_PCT) / PMFS_PCT_FULL);
    localparam logic [SET_W:0] I_MARGIN =
        (SET_W+1)'((RATED_I * PMFS_MARGIN_PCT) / PMFS_PCT_FULL);

    pmfs_state_t state_r;
    pmfs_state_t state_nxt;

    logic open_now;
    logic trk_trip;
    logic cat_ev;
    logic acc;
    logic wr;
    logic [SET_W:0] vlim;
    logic [SET_W:0] ilim;

    // ==========================================================
    // fault detection
    // an excess lead drop looks the same as a broken lead
    assign open_now = open_lead_i | lead_drop_hi_i; // RQ16
    assign vlim = {1'b0, state_r.vset} + V_MARGIN;
    assign ilim = {1'b0, state_r.iset} + I_MARGIN;
    // compare against programmed value, not the live output
    assign trk_trip = ({1'b0, vmeas_i} > vlim) |
        ({1'b0, imeas_i} > ilim); // RQ9
    // all four catastrophic classes share one shutdown path
    assign cat_ev = trk_trip | bulk_low_i | (|therm_hot_i); // RQ1
    assign acc = psel_i & penable_i & ~state_r.ready;
    assign wr = acc & pwrite_i;

    // ==========================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        state_nxt.ready = acc;
        state_nxt.err = 1'b0;
        state_nxt.rdata = 32'h00000000;
        // register writes, dropped for enable/setpoints once latched
        if (wr && !state_r.cat && !state_r.open_st) begin // RQ17
            unique case (paddr_i)
                PMFS_CTRL_OFS: begin
                    state_nxt.en = pwdata_i[PMFS_CTRL_EN_BIT];
                    state_nxt.cmode = pwdata_i[PMFS_CTRL_CMODE_BIT];
                end
                PMFS_VSET_OFS: state_nxt.vset = pwdata_i[SET_W-1:0];
                PMFS_ISET_OFS: state_nxt.iset = pwdata_i[SET_W-1:0];
                default: ;
            endcase
        end
        // restore command clears the catastrophic latch after power-on
        if (wr && paddr_i == PMFS_CMD_OFS &&
            pwdata_i[PMFS_CMD_RESTORE_BIT]) begin // RQ8
            state_nxt.cat = 1'b0;
            state_nxt.trk = 1'b0;
            state_nxt.therm = 1'b0;
        end
        // open-lead message ack; a fresh detection wins over the clear
        if (wr && paddr_i == PMFS_CMD_OFS &&
            pwdata_i[PMFS_CMD_OPENCLR_BIT]) begin
            state_nxt.open_seen = 1'b0;
        end
        // reads
        if (acc && !pwrite_i) begin
            unique case (paddr_i)
                PMFS_CTRL_OFS: begin
                    state_nxt.rdata[PMFS_CTRL_EN_BIT] = state_r.en;
                    state_nxt.rdata[PMFS_CTRL_CMODE_BIT] = state_r.cmode;
                end
                PMFS_VSET_OFS: state_nxt.rdata[SET_W-1:0] = state_r.vset;
                PMFS_ISET_OFS: state_nxt.rdata[SET_W-1:0] = state_r.iset;
                PMFS_STAT_OFS: begin
                    state_nxt.rdata[PMFS_ST_CAT_BIT] = state_r.cat;
                    state_nxt.rdata[PMFS_ST_TRK_BIT] = state_r.trk;
                    state_nxt.rdata[PMFS_ST_THERM_BIT] = state_r.therm;
                    state_nxt.rdata[PMFS_ST_OPEN_BIT] = state_r.open_seen;
                    state_nxt.rdata[PMFS_ST_OPENNOW_BIT] = state_r.open_st;
                    state_nxt.rdata[PMFS_ST_CONV_BIT] = state_r.conv;
                    state_nxt.rdata[PMFS_ST_ENAB_BIT] = state_r.en;
                    state_nxt.rdata[PMFS_ST_CMODE_BIT] = state_r.cmode;
                end
                PMFS_CMD_OFS: ;
                PMFS_MEAS_OFS: begin
                    state_nxt.rdata[SET_W-1:0] = vmeas_i;
                    state_nxt.rdata[SET_W+15:16] = imeas_i;
                end
                default: state_nxt.err = acc;
            endcase
        end
        if (wr && paddr_i > PMFS_MEAS_OFS) begin
            state_nxt.err = 1'b1;
        end
        // catastrophic fault: latch flags, set wins over restore
        if (cat_ev) begin // RQ1
            state_nxt.cat = 1'b1;
            state_nxt.trk = state_nxt.trk | trk_trip | bulk_low_i; // RQ12
            state_nxt.therm = state_nxt.therm | (|therm_hot_i); // RQ10
        end
        // open lead: voltage mode, disabled, zero setpoints
        state_nxt.open_st = open_now; // RQ15
        if (open_now) begin // RQ13
            state_nxt.open_seen = 1'b1; // RQ14
            state_nxt.en = 1'b0;
            state_nxt.cmode = 1'b0;
            state_nxt.vset = PMFS_SET_RST;
            state_nxt.iset = PMFS_SET_RST;
        end
        // catastrophic latch kills the programmed state too
        if (state_nxt.cat) begin // RQ3
            state_nxt.en = 1'b0;
            state_nxt.vset = PMFS_SET_RST;
            state_nxt.iset = PMFS_SET_RST;
        end
        // outputs: relays open in the same edge as the trip
        state_nxt.prl = state_nxt.en ? 4'hF : 4'h0; // RQ2
        state_nxt.srl = state_nxt.en ? 2'h3 : 2'h0; // RQ2
        state_nxt.vo = state_nxt.vset; // RQ3
        state_nxt.io = state_nxt.iset; // RQ3
        // thermal latch holds converter off after cool-down
        state_nxt.conv = ~state_nxt.cat; // RQ4 RQ11
        state_nxt.cm_o = state_nxt.cmode;
        state_nxt.catf = state_nxt.cat; // RQ5
        state_nxt.openm = state_nxt.open_seen; // RQ14
    end

    // ==========================================================
    // state register
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= '0;
            state_r.conv <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata_o = state_r.rdata;
    assign pready_o = state_r.ready;
    assign pslverr_o = state_r.err;
    assign pwr_relay_o = state_r.prl;
    assign sig_relay_o = state_r.srl;
    assign vset_o = state_r.vo;
    assign iset_o = state_r.io;
    assign conv_on_o = state_r.conv;
    assign cur_mode_o = state_r.cm_o;
    assign cat_flag_o = state_r.catf;
    assign open_msg_o = state_r.openm;

    // ==========================================================
    // checks
    relay_open_a: assert property ( // RQ2
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cat_ev |=> (pwr_relay_o == 4'h0 && sig_relay_o == 2'h0))
        else $error("relays not opened after fault");
    setp_zero_a: assert property ( // RQ3
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cat_ev |=> (vset_o == '0 && iset_o == '0))
        else $error("setpoints not zero after fault");
    conv_latch_a: assert property ( // RQ4
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cat_flag_o |-> !conv_on_o)
        else $error("converter on while fault latched");
    cat_flag_a: assert property ( // RQ5
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cat_ev |=> cat_flag_o)
        else $error("catastrophic flag missing");
    therm_hold_a: assert property ( // RQ11
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cat_flag_o && !(wr && paddr_i == PMFS_CMD_OFS &&
        pwdata_i[PMFS_CMD_RESTORE_BIT])) |=> cat_flag_o)
        else $error("fault latch released without restore");
    open_resp_a: assert property ( // RQ13
        @(posedge core_clk_i) disable iff (!rst_n_i)
        open_now |=> (!cur_mode_o && pwr_relay_o == 4'h0 &&
        ((conv_on_o == $past(conv_on_o)) || $past(cat_ev))) ##0 open_msg_o)
        else $error("open lead response wrong");
    drop_open_a: assert property ( // RQ16
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (lead_drop_hi_i && !open_lead_i) |=> open_msg_o)
        else $error("lead drop not treated as open");
    lock_cmd_a: assert property ( // RQ17
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cat_flag_o && !cat_ev) |=> ##1 (vset_o == '0 && pwr_relay_o == 4'h0))
        else $error("commands obeyed while latched");
    trk_trip_a: assert property ( // RQ9
        @(posedge core_clk_i) disable iff (!rst_n_i)
        trk_trip |=> ##1 pwr_relay_o == 4'h0)
        else $error("tracking fault did not shut down");

    // ==========================================================
    // cause flags and the open-lead path, which must not latch
    trk_flag_a: assert property ( // RQ9
        @(posedge core_clk_i) disable iff (!rst_n_i)
        trk_trip |=> (state_r.trk && cat_flag_o))
        else $error("tracking cause not flagged");
    therm_flag_a: assert property ( // RQ10
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (|therm_hot_i) |=> (state_r.therm && cat_flag_o))
        else $error("thermal cause not flagged");
    bulk_flag_a: assert property ( // RQ12
        @(posedge core_clk_i) disable iff (!rst_n_i)
        bulk_low_i |=> (state_r.trk && cat_flag_o))
        else $error("power loss cause not flagged");
    conv_off_a: assert property ( // RQ4
        @(posedge core_clk_i) disable iff (!rst_n_i)
        cat_ev |=> !conv_on_o)
        else $error("converter not latched off");
    open_conv_a: assert property ( // RQ13
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (open_now && !cat_ev && !cat_flag_o) |=> conv_on_o)
        else $error("open lead latched the converter");
    open_zero_a: assert property ( // RQ13
        @(posedge core_clk_i) disable iff (!rst_n_i)
        open_now |=> (vset_o == '0 && iset_o == '0 && sig_relay_o == 2'h0))
        else $error("open lead left output live");
    open_msg_a: assert property ( // RQ14
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(open_msg_o) |-> (!cur_mode_o && pwr_relay_o == 4'h0))
        else $error("open lead message out of step");
    open_free_a: assert property ( // RQ15
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == PMFS_VSET_OFS && !state_r.open_st &&
        !cat_flag_o && !cat_ev && !open_now) |=>
        (state_r.vset == $past(pwdata_i[SET_W-1:0])))
        else $error("setpoint write refused after open lead");
    restore_ok_a: assert property ( // RQ8
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (wr && paddr_i == PMFS_CMD_OFS && !cat_ev &&
        pwdata_i[PMFS_CMD_RESTORE_BIT]) |=> (conv_on_o && !cat_flag_o))
        else $error("restore did not release the latch");
endmodule
`default_nettype wire

// file: tb/pmfs_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// controller view of one module address on the control bus
module pmfs_ctrl_model (
    // clock
    input wire logic core_clk_i,
    // module flag and controller command
    input wire logic cat_flag_i,
    input wire logic restore_i,
    output var logic listed_o
);
    initial listed_o = 1'b1;
    // a power cycle alone never relists, so no reset term here
    // plain always: the start-up value above comes from an initial block
    always @(posedge core_clk_i) begin
        if (cat_flag_i) begin
            listed_o <= 1'b0;
        end else if (restore_i) begin
            listed_o <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// file: tb/pmfs_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// bench for the fault supervisor
module pmfs_supervisor_tb;
    import pmfs_pkg::*;
    logic core_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, cat, omsg, conv, cmode, listed;
    logic [11:0] vm = 12'h000, im = 12'h000, vs, is;
    logic [1:0] th = 2'h0, sr;
    logic bulk = 0, olead = 0, ldrop = 0, rest = 0;
    logic [3:0] pr;
    int bad_count = 0, total_checks = 0;
    always #50 core_clk_i = ~core_clk_i;
    pmfs_supervisor i_pmfs_supervisor (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .vmeas_i(vm), .imeas_i(im),
        .therm_hot_i(th), .bulk_low_i(bulk), .open_lead_i(olead),
        .lead_drop_hi_i(ldrop), .pwr_relay_o(pr), .sig_relay_o(sr),
        .vset_o(vs), .iset_o(is), .conv_on_o(conv), .cur_mode_o(cmode),
        .cat_flag_o(cat), .open_msg_o(omsg));
    pmfs_ctrl_model i_pmfs_ctrl_model (.core_clk_i(core_clk_i),
        .cat_flag_i(cat), .restore_i(rest), .listed_o(listed));
    task tick(input int n);
        repeat (n) @(posedge core_clk_i);
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk_i);
        pen <= 1;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            bad_count++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        pen <= 0;
    endtask
    task arm(input logic [31:0] c);
        apb(1, PMFS_VSET_OFS, 32'h100);
        apb(1, PMFS_ISET_OFS, 32'h080);
        apb(1, PMFS_CTRL_OFS, c);
        tick(3);
        chk(pr, 4'hF);
        chk(vs, 12'h100);
    endtask
    // one catastrophic trip: shut down, stay latched, refuse, restore
    task trip(input logic [11:0] v, i, input logic [1:0] t,
              input logic b, input int sbit);
        arm(32'h1);
        vm <= v; im <= i; th <= t; bulk <= b;
        tick(2);
        chk({pr, sr}, 6'h00);
        chk({vs, is}, 24'h0);
        chk({conv, cat}, 2'b01);
        vm <= 0; im <= 0; th <= 0; bulk <= 0;
        apb(0, PMFS_STAT_OFS, 0);
        chk(rd[sbit], 1'b1);
        chk(listed, 1'b0);
        apb(1, PMFS_CTRL_OFS, 32'h1);
        apb(1, PMFS_VSET_OFS, 32'h200);
        tick(3);
        chk({pr, vs, conv, cat}, 18'h1);
        // source power removed and reapplied before the restore command
        rst_n_i <= 0;
        tick(6);
        rst_n_i <= 1;
        tick(2);
        chk(listed, 1'b0);
        chk({conv, cat}, 2'b10);
        rest <= 1;
        apb(1, PMFS_CMD_OFS, 32'h1);
        rest <= 0;
        tick(3);
        chk({conv, cat, listed}, 3'b101);
        $display("trip bit %0d done", sbit);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        tick(6);
        rst_n_i <= 1;
        tick(1);
        chk({pr, sr, vs, is, conv, cat, omsg}, 33'h4);
        arm(32'h1);
        vm <= 12'h299; // exactly rated margin over: no trip
        im <= 12'h219;
        tick(3);
        chk(cat, 1'b0);
        apb(0, PMFS_MEAS_OFS, 0);
        chk(rd, 32'h0219_0299);
        apb(0, 8'h18, 0);
        chk(err, 1'b1);
        $display("margin and map done");
        trip(12'h29A, 12'h000, 2'h0, 0, PMFS_ST_TRK_BIT);
        trip(12'h000, 12'h21A, 2'h0, 0, PMFS_ST_TRK_BIT);
        trip(12'h000, 12'h000, 2'h1, 0, PMFS_ST_THERM_BIT);
        trip(12'h000, 12'h000, 2'h2, 0, PMFS_ST_THERM_BIT);
        trip(12'h000, 12'h000, 2'h0, 1, PMFS_ST_TRK_BIT);
        // open lead and excess lead drop act alike and do not latch
        for (int k = 0; k < 2; k++) begin
            arm(32'h3);
            chk(cmode, 1'b1);
            olead <= (k == 0);
            ldrop <= (k == 1);
            tick(2);
            chk({pr, sr, vs, is, cmode}, 31'h0);
            chk({conv, cat, omsg}, 3'b101);
            olead <= 0;
            ldrop <= 0;
            arm(32'h1);
            apb(1, PMFS_CMD_OFS, 32'h2);
            tick(3);
            chk(omsg, 1'b0);
            $display("open lead case %0d done", k);
        end
        tally_and_finish;
    end
    initial begin
        tick(3000);
        bad_count++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
